// File: core/bha_pkg.sv
// Package for the bus hold and cycle priority arbiter
package bha_pkg;

  localparam int REQ_COUNT = 10;
  localparam int CYC_LEN_W = 4;

  // Request slots, highest priority first
  typedef enum logic [3:0] {
    SRC_EXEC_NP,
    SRC_REFRESH,
    SRC_HOLD,
    SRC_STEP,
    SRC_NMI,
    SRC_INT_ERR,
    SRC_HW_INT,
    SRC_MATH_ERR,
    SRC_GEN_EXEC,
    SRC_PREFETCH,
    SRC_NONE
  } bha_src_e;

  localparam logic [3:0] SRC_IDX_REFRESH = 4'h1;
  localparam logic [3:0] SRC_IDX_HOLD = 4'h2;

  typedef enum logic [1:0] {
    ATTR_PLAIN,
    ATTR_ODD_WORD,
    ATTR_LOAD_STORE,
    ATTR_STRING
  } bha_attr_e;

  // One internal bus cycle request
  typedef struct packed {
    logic valid;
    logic locked;
    bha_attr_e attr;
  } bha_req_s;

  // Bus cycle start handed to the bus sequencer
  typedef struct packed {
    logic start;
    bha_src_e src;
    logic locked;
  } bha_grant_s;

  localparam logic [CYC_LEN_W-1:0] HOLD_LAT_CYC = 4'h2;

endpackage

// File: core/bha_prio_enc.sv
// Fixed priority encoder over request slots
`timescale 1ns/1ns
module bha_prio_enc (
  // Requests
  input wire logic [bha_pkg::REQ_COUNT-1:0] req,
  // Winner
  output logic any,
  output logic [3:0] idx
);
  import bha_pkg::*;

  always_comb begin
    any = 1'b0;
    idx = 4'h0;
    for (int i = REQ_COUNT - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = 4'(i);
      end
    end
  end

endmodule

// File: core/bha_arbiter.sv
// Bus hold handshake and bus cycle priority arbiter
// Contract
// - Request back during refresh: finish refresh, float, acknowledge again.
// - On hold exit start pending cycle; with none, bus stays floating.
// - Rank: non-pipelined execution, then refresh, then hold request.
// - Then single-step, NMI, internal error, hardware, coprocessor error vectoring.
// - Then general execution ninth, prefetch fill cycles last.
// - Second cycle of odd word follows first with nothing between.
// - Load/store read and write may be split by other cycles.
// - String instruction cycles may be interleaved with other cycles.
// - Locked instruction cycles take top priority and run unsplit.
// - Master requests, waits for acknowledge, owns bus until request drops.
// - Refresh during hold drops acknowledge; bus retaken only after request drops.
// - Request to acknowledge is two clocks at least, when bus idle.
`timescale 1ns/1ns
module bha_arbiter (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // External master handshake
  input wire logic hold_req,
  output logic bus_grant_ack,
  output logic bus_float_n,
  // Internal requests, by slot
  input wire bha_pkg::bha_req_s exec_np_req,
  input wire logic refresh_req,
  input wire logic step_req,
  input wire logic nmi_req,
  input wire logic int_err_req,
  input wire logic hw_int_req,
  input wire logic math_err_req,
  input wire bha_pkg::bha_req_s gen_exec_req,
  input wire logic prefetch_req,
  // Bus sequencer
  input wire logic bus_ready,
  input wire logic cycle_done,
  output bha_pkg::bha_grant_s grant,
  output logic bus_lock_n
);
  import bha_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_BUSY,
    ST_HOLD_WAIT,
    ST_HOLD,
    ST_HOLD_RFSH,
    ST_RFSH
  } bha_state_e;

  bha_state_e state_q, state_d;
  logic hold_s1_q, hold_s2_q;
  logic hold_s1_d, hold_s2_d;
  logic [CYC_LEN_W-1:0] lat_q, lat_d;
  logic lock_q, lock_d;
  logic tie_q, tie_d;
  bha_src_e cur_q, cur_d;
  bha_grant_s grant_q, grant_d;
  logic ack_q, ack_d;
  logic [REQ_COUNT-1:0] req_vec;
  logic win_any;
  logic [3:0] win_idx;
  logic boundary;

  // Hold request comes from another master's clock
  always_comb begin
    hold_s1_d = hold_req;
    hold_s2_d = hold_s1_q;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hold_s1_q <= 1'b0;
      hold_s2_q <= 1'b0;
    end else begin
      hold_s1_q <= hold_s1_d;
      hold_s2_q <= hold_s2_d;
    end
  end

  // Boundary: idle, or current cycle completing with ready
  assign boundary = (state_q == ST_IDLE) ||
                    (state_q == ST_BUSY && cycle_done && bus_ready);

  always_comb begin
    req_vec = '0;
    req_vec[SRC_EXEC_NP] = exec_np_req.valid;
    req_vec[SRC_REFRESH] = refresh_req;
    req_vec[SRC_HOLD] = hold_s2_q && !lock_q;
    req_vec[SRC_STEP] = step_req;
    req_vec[SRC_NMI] = nmi_req;
    req_vec[SRC_INT_ERR] = int_err_req;
    req_vec[SRC_HW_INT] = hw_int_req;
    req_vec[SRC_MATH_ERR] = math_err_req;
    req_vec[SRC_GEN_EXEC] = gen_exec_req.valid;
    req_vec[SRC_PREFETCH] = prefetch_req;
  end

  bha_prio_enc u_prio (
    .req(req_vec),
    .any(win_any),
    .idx(win_idx)
  );

  always_comb begin
    state_d = state_q;
    lat_d = lat_q;
    lock_d = lock_q;
    tie_d = tie_q;
    cur_d = cur_q;
    grant_d = '{start: 1'b0, src: SRC_NONE, locked: 1'b0};
    ack_d = ack_q;
    case (state_q)
      ST_IDLE, ST_BUSY: begin
        if (boundary) begin
          if (state_q == ST_BUSY) begin
            lock_d = 1'b0;
          end
          if (tie_q || lock_q) begin
            // Tied or locked sequence owns the next cycle
            grant_d = '{start: 1'b1, src: cur_q, locked: lock_q};
            tie_d = 1'b0;
            lock_d = lock_q && (cur_q == SRC_EXEC_NP ? exec_np_req.locked
                                                    : gen_exec_req.locked);
            state_d = ST_BUSY;
          end else if (win_any && win_idx == SRC_IDX_HOLD) begin
            state_d = ST_HOLD_WAIT;
            lat_d = '0;
          end else if (win_any) begin
            // Load/store and string cycles rearbitrate each time
            cur_d = bha_src_e'(win_idx);
            grant_d = '{start: 1'b1, src: bha_src_e'(win_idx), locked: 1'b0};
            if (win_idx == 4'(SRC_EXEC_NP)) begin
              tie_d = exec_np_req.attr == ATTR_ODD_WORD;
              lock_d = exec_np_req.locked;
            end else if (win_idx == 4'(SRC_GEN_EXEC)) begin
              tie_d = gen_exec_req.attr == ATTR_ODD_WORD;
              lock_d = gen_exec_req.locked;
            end
            grant_d.locked = lock_d;
            state_d = ST_BUSY;
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_HOLD_WAIT: begin
        lat_d = lat_q + 4'h1;
        if (!hold_s2_q) begin
          state_d = ST_IDLE;
        end else if (refresh_req) begin
          // Refresh outranks hold before acknowledge
          state_d = ST_IDLE;
        end else if (lat_q + 4'h1 >= HOLD_LAT_CYC - 4'h1) begin
          ack_d = 1'b1;
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!hold_s2_q) begin
          ack_d = 1'b0;
          state_d = ST_IDLE;
        end else if (refresh_req) begin
          ack_d = 1'b0;
          state_d = ST_HOLD_RFSH;
        end
      end
      ST_HOLD_RFSH: begin
        // Master relies on a one clock acknowledge being seen
        if (!hold_s2_q) begin
          grant_d = '{start: 1'b1, src: SRC_REFRESH, locked: 1'b0};
          state_d = ST_RFSH;
        end
      end
      ST_RFSH: begin
        if (cycle_done && bus_ready) begin
          if (hold_s2_q) begin
            ack_d = 1'b1;
            state_d = ST_HOLD;
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      lat_q <= '0;
      lock_q <= 1'b0;
      tie_q <= 1'b0;
      cur_q <= SRC_NONE;
      grant_q <= '{start: 1'b0, src: SRC_NONE, locked: 1'b0};
      ack_q <= 1'b0;
    end else begin
      state_q <= state_d;
      lat_q <= lat_d;
      lock_q <= lock_d;
      tie_q <= tie_d;
      cur_q <= cur_d;
      grant_q <= grant_d;
      ack_q <= ack_d;
    end
  end

  assign grant = grant_q;
  assign bus_grant_ack = ack_q;
  // Bus floats in hold and its wait states, and whenever idle, not only after hold
  assign bus_float_n = !(ack_q || state_q == ST_HOLD_WAIT || state_q == ST_HOLD_RFSH ||
                         state_q == ST_IDLE);
  assign bus_lock_n = !lock_q;

endmodule

// File: tb/bha_master_model.sv
// External bus master model for the hold handshake
`timescale 1ns/1ns
module bha_master_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Handshake
  input wire logic want,
  input wire logic bus_grant_ack,
  output logic hold_req,
  output logic ack_seen
);
  logic hold_d;
  logic seen_d;
  always_comb begin
    seen_d = hold_req && (ack_seen || bus_grant_ack);
    hold_d = want && !(ack_seen && !bus_grant_ack);
  end
  always_ff @(posedge core_clk) begin
    hold_req <= rst_n && hold_d;
    ack_seen <= rst_n && seen_d;
  end
endmodule

// File: tb/bha_arbiter_sva.sv
// Checker for the bus hold arbiter
`timescale 1ns/1ns
module bha_arbiter_chk (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hold_req,
  input wire logic bus_grant_ack,
  input wire logic bus_float_n,
  input wire bha_pkg::bha_req_s exec_np_req,
  input wire logic refresh_req,
  input wire logic nmi_req,
  input wire bha_pkg::bha_req_s gen_exec_req,
  input wire bha_pkg::bha_grant_s grant,
  input wire logic bus_lock_n
);
  import bha_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  bha_attr_e attr_q;
  logic odd_q;
  always_ff @(posedge core_clk) begin
    attr_q <= gen_exec_req.attr;
    odd_q <= !rst_n ? 1'b0 : grant.start ? grant.src == SRC_GEN_EXEC &&
      attr_q == ATTR_ODD_WORD && !odd_q : odd_q;
  end
  AST_START_PULSE: assert property (grant.start |=> !grant.start)
    else $error("start longer than one cycle");
  AST_PRIO_LOW: assert property (grant.start && grant.src == SRC_PREFETCH |->
    !$past(exec_np_req.valid || refresh_req || nmi_req || gen_exec_req.valid))
    else $error("prefetch beat a higher request");
  AST_EXEC_WINS: assert property (grant.start && $past(exec_np_req.valid) && bus_lock_n &&
    !odd_q |-> grant.src == SRC_EXEC_NP) else $error("execution request lost");
  AST_ACK_LAT: assert property ($rose(bus_grant_ack) |-> $past(hold_req, 2))
    else $error("acknowledge too early");
  AST_ACK_FLOAT: assert property (bus_grant_ack |-> !bus_float_n)
    else $error("bus driven in hold");
  AST_REFR_DROP: assert property (bus_grant_ack && refresh_req |=> !bus_grant_ack)
    else $error("acknowledge kept on refresh");
  AST_ODD_PAIR: assert property (grant.start && odd_q |-> grant.src == SRC_GEN_EXEC &&
    !bus_grant_ack) else $error("odd word split");
  AST_LOCK_NO_ACK: assert property (!bus_lock_n |-> !bus_grant_ack)
    else $error("hold granted while locked");
  cover property (grant.start && odd_q);
  cover property (bus_grant_ack && refresh_req);
  cover property ($fell(bus_lock_n));
endmodule
bind bha_arbiter bha_arbiter_chk u_chk (.core_clk(core_clk), .rst_n(rst_n),
  .hold_req(hold_req), .bus_grant_ack(bus_grant_ack), .bus_float_n(bus_float_n),
  .exec_np_req(exec_np_req), .refresh_req(refresh_req), .nmi_req(nmi_req),
  .gen_exec_req(gen_exec_req), .grant(grant), .bus_lock_n(bus_lock_n));

// File: tb/bha_arbiter_test.sv
// Testbench for the bus hold arbiter
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module bha_arbiter_test;
  import bha_pkg::*;
  logic core_clk, rst_n, want, el, cyc_done, hold_req, ack, flt_n, lock_n, got, rdy;
  logic [9:0] r;
  bha_attr_e ga;
  bha_req_s enp, gex;
  bha_grant_s grant;
  int mismatches, num_checks;
  assign enp = {r[0], el, ATTR_PLAIN};
  assign gex = {r[8], 1'b0, ga};
  bha_master_model mst (.core_clk(core_clk), .rst_n(rst_n), .want(want),
    .bus_grant_ack(ack), .hold_req(hold_req), .ack_seen(got));
  bha_arbiter dut (.core_clk(core_clk), .rst_n(rst_n), .hold_req(hold_req),
    .bus_grant_ack(ack), .bus_float_n(flt_n), .exec_np_req(enp), .refresh_req(r[1]),
    .step_req(r[3]), .nmi_req(r[4]), .int_err_req(r[5]), .hw_int_req(r[6]),
    .math_err_req(r[7]), .gen_exec_req(gex), .prefetch_req(r[9]), .bus_ready(rdy),
    .cycle_done(cyc_done), .grant(grant), .bus_lock_n(lock_n));
  task automatic tick();
    @(posedge core_clk);
    #2;
  endtask
  task automatic done();
    tick();
    cyc_done = 1'b1;
    tick();
    cyc_done = 1'b0;
  endtask
  // Last clock stretched by two not-ready clocks
  task automatic slow_done();
    tick();
    {rdy, cyc_done} = 2'b01;
    repeat (2) tick();
    `CHK(grant.start, 1'b0)
    `CHK(ack, 1'b0)
    rdy = 1'b1;
    tick();
    cyc_done = 1'b0;
  endtask
  task automatic serve(input bha_src_e s, input logic keep);
    int n;
    n = 0;
    while (grant.start !== 1'b1 && n < 60) begin
      tick();
      n++;
    end
    `CHK(grant.src, s)
    r[s] = keep;
  endtask
  task automatic wait_ack();
    int n;
    n = 0;
    while (got !== 1'b1 && n < 60) begin
      tick();
      n++;
    end
    `CHK(ack, 1'b1)
  endtask
  task automatic t_prio();
    r = 10'h3FB;
    for (int i = 0; i < 10; i++) begin
      if (i != 2) begin
        serve(bha_src_e'(i), 1'b0);
        done();
      end
    end
  endtask
  task automatic t_hold();
    want = 1'b1;
    wait_ack();
    `CHK(flt_n, 1'b0)
    r[1] = 1'b1;
    tick();
    `CHK(ack, 1'b0)
    serve(SRC_REFRESH, 1'b0);
    done();
    wait_ack();
    r[9] = 1'b1;
    want = 1'b0;
    serve(SRC_PREFETCH, 1'b0);
    done();
    repeat (4) tick();
    `CHK(flt_n, 1'b0)
  endtask
  task automatic t_odd();
    ga = ATTR_ODD_WORD;
    r[8] = 1'b1;
    serve(SRC_GEN_EXEC, 1'b1);
    ga = ATTR_PLAIN;
    r[1] = 1'b1;
    done();
    serve(SRC_GEN_EXEC, 1'b0);
    done();
    serve(SRC_REFRESH, 1'b0);
    done();
    ga = ATTR_STRING;
    r[8] = 1'b1;
    serve(SRC_GEN_EXEC, 1'b1);
    r[1] = 1'b1;
    done();
    serve(SRC_REFRESH, 1'b0);
    ga = ATTR_LOAD_STORE;
    done();
    serve(SRC_GEN_EXEC, 1'b1);
    r[1] = 1'b1;
    done();
    serve(SRC_REFRESH, 1'b0);
    ga = ATTR_PLAIN;
    done();
    serve(SRC_GEN_EXEC, 1'b0);
    done();
  endtask
  task automatic t_lock();
    el = 1'b1;
    r[0] = 1'b1;
    r[9] = 1'b1;
    want = 1'b1;
    serve(SRC_EXEC_NP, 1'b1);
    `CHK(grant.locked, 1'b1)
    `CHK(lock_n, 1'b0)
    el = 1'b0;
    done();
    serve(SRC_EXEC_NP, 1'b0);
    `CHK(ack, 1'b0)
    slow_done();
    wait_ack();
    `CHK(lock_n, 1'b1)
    want = 1'b0;
    serve(SRC_PREFETCH, 1'b0);
    done();
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    #300000;
    mismatches++;
    wrap_up();
  end
  initial begin
    {rst_n, want, el, cyc_done, r} = '0;
    ga = ATTR_PLAIN;
    rdy = 1'b1;
    repeat (12) @(posedge core_clk);
    #2;
    rst_n = 1'b1;
    tick();
    t_prio();
    t_hold();
    t_odd();
    t_lock();
    wrap_up();
  end
endmodule
